// File: rtl/pdvc_src_seq.sv
// source policy sequencer for a contract that lowers voltage and current
// What this block does
// - start only on request; send Accept first
// - wait tSrcTransition after Accept GoodCRC
// - command supply change, ready within tSrcReady
// - supply readiness gates PS_RDY; without it the tSrcReady timeout returns to idle
// - send PS_RDY, then expect its GoodCRC
`timescale 1ns/100ps
`default_nettype none
module pdvc_src_seq #(
   parameter logic [23:0] TRANS_CYC = pdvc_pkg::T_SRC_TRANS_CYC,
   parameter logic [23:0] READY_CYC = pdvc_pkg::T_SRC_READY_CYC,
   parameter logic [23:0] CRC_CYC = pdvc_pkg::CRC_WAIT_CYC
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // policy request and protocol layer receive side
   input wire logic req_rx_i,
   input wire logic goodcrc_rx_i,
   // protocol layer transmit side
   input wire logic tx_ready_i,
   output logic tx_valid_o,
   output pdvc_pkg::pdvc_msg_t tx_msg_o,
   // device policy manager and supply
   output logic supply_cmd_o,
   input wire logic supply_ready_i,
   // status
   output pdvc_pkg::pdvc_stat_t stat_o
);

   // ******************************
   // state machine
   // ******************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SEND_ACC,
      ST_WAIT_ACC_CRC,
      ST_WAIT_TRANS,
      ST_CMD_SUPPLY,
      ST_WAIT_READY,
      ST_SEND_PSRDY,
      ST_WAIT_PSRDY_CRC
   } pdvc_state_t;

   pdvc_state_t state_q;
   pdvc_state_t state_d;
   logic [23:0] timer_q;
   logic [23:0] since_crc_q;
   pdvc_pkg::pdvc_msg_t tx_msg_q;
   pdvc_pkg::pdvc_stat_t stat_q;
   logic crc_tmo;
   logic ready_tmo;

   assign crc_tmo = (timer_q == CRC_CYC - 24'h000001);
   assign ready_tmo = (timer_q == READY_CYC - 24'h000001);

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (req_rx_i)
            begin
               state_d = ST_SEND_ACC;
            end
         end
         ST_SEND_ACC:
         begin
            if (tx_ready_i)
            begin
               state_d = ST_WAIT_ACC_CRC;
            end
         end
         ST_WAIT_ACC_CRC:
         begin
            if (goodcrc_rx_i)
            begin
               state_d = ST_WAIT_TRANS;
            end
            else if (crc_tmo)
            begin
               state_d = ST_IDLE;
            end
         end
         ST_WAIT_TRANS:
         begin
            if (timer_q == TRANS_CYC - 24'h000001)
            begin
               state_d = ST_CMD_SUPPLY;
            end
         end
         ST_CMD_SUPPLY:
         begin
            state_d = ST_WAIT_READY;
         end
         ST_WAIT_READY:
         begin
            if (supply_ready_i)
            begin
               state_d = ST_SEND_PSRDY;
            end
            else if (ready_tmo)
            begin
               state_d = ST_IDLE;
            end
         end
         ST_SEND_PSRDY:
         begin
            if (tx_ready_i)
            begin
               state_d = ST_WAIT_PSRDY_CRC;
            end
         end
         ST_WAIT_PSRDY_CRC:
         begin
            if (goodcrc_rx_i || crc_tmo)
            begin
               state_d = ST_IDLE;
            end
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q <= ST_IDLE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // ******************************
   // state timer
   // ******************************
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         timer_q <= pdvc_pkg::TIMER_RST;
      end
      else if (state_d != state_q)
      begin
         timer_q <= pdvc_pkg::TIMER_RST;
      end
      else
      begin
         timer_q <= timer_q + 24'h000001;
      end
   end

   // ******************************
   // transmit request
   // ******************************
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tx_msg_q <= pdvc_pkg::PDVC_MSG_NONE;
      end
      else if (state_d == ST_SEND_ACC)
      begin
         tx_msg_q <= pdvc_pkg::PDVC_MSG_ACCEPT;
      end
      else if (state_d == ST_SEND_PSRDY)
      begin
         tx_msg_q <= pdvc_pkg::PDVC_MSG_PS_RDY;
      end
      else
      begin
         tx_msg_q <= pdvc_pkg::PDVC_MSG_NONE;
      end
   end

   assign tx_valid_o = (state_q == ST_SEND_ACC) || (state_q == ST_SEND_PSRDY);
   assign tx_msg_o = tx_msg_q;
   assign supply_cmd_o = (state_q == ST_CMD_SUPPLY);

   // ******************************
   // status
   // ******************************
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stat_q <= pdvc_pkg::STAT_RST;
      end
      else
      begin
         stat_q.busy <= (state_d != ST_IDLE);
         stat_q.done <= (state_q == ST_WAIT_PSRDY_CRC) && goodcrc_rx_i;
         stat_q.err_crc <= !goodcrc_rx_i && crc_tmo &&
            ((state_q == ST_WAIT_ACC_CRC) || (state_q == ST_WAIT_PSRDY_CRC));
         stat_q.err_ready <= (state_q == ST_WAIT_READY) && !supply_ready_i && ready_tmo;
      end
   end

   assign stat_o = stat_q;

   // ******************************
   // checks
   // ******************************
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         since_crc_q <= pdvc_pkg::TIMER_RST;
      end
      else if (state_q == ST_WAIT_ACC_CRC)
      begin
         since_crc_q <= pdvc_pkg::TIMER_RST;
      end
      else if (state_q == ST_WAIT_TRANS)
      begin
         since_crc_q <= since_crc_q + 24'h000001;
      end
   end

   AST_START_ON_REQ: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(stat_o.busy) |-> $past(req_rx_i) && tx_valid_o &&
         (tx_msg_o == pdvc_pkg::PDVC_MSG_ACCEPT))
      else $error("sequence began without a request or without Accept");

   AST_CMD_AFTER_TRANS: assert property (@(posedge core_clk_i) disable iff (rst_i)
      supply_cmd_o |-> (since_crc_q == TRANS_CYC))
      else $error("supply commanded before tSrcTransition elapsed");

   AST_CMD_ONE_PULSE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      supply_cmd_o |=> !supply_cmd_o && (state_q == ST_WAIT_READY))
      else $error("supply command not a single pulse");

   AST_READY_TIMEOUT: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (state_q == ST_WAIT_READY) && !supply_ready_i && ready_tmo |=>
         stat_o.err_ready && (state_q == ST_IDLE))
      else $error("supply readiness timeout not reported");

   AST_PSRDY_AFTER_READY: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(tx_msg_o == pdvc_pkg::PDVC_MSG_PS_RDY) |->
         $past(supply_ready_i) && $past(state_q == ST_WAIT_READY))
      else $error("PS_RDY sent without supply readiness");

   AST_PSRDY_THEN_CRC: assert property (@(posedge core_clk_i) disable iff (rst_i)
      tx_valid_o && tx_ready_i && (tx_msg_o == pdvc_pkg::PDVC_MSG_PS_RDY) |=>
         (state_q == ST_WAIT_PSRDY_CRC) && !tx_valid_o)
      else $error("PS_RDY not followed by acknowledgement wait");

   AST_DONE_ON_CRC: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (state_q == ST_WAIT_PSRDY_CRC) && goodcrc_rx_i |=> stat_o.done ##1 !stat_o.done)
      else $error("completion not flagged after PS_RDY acknowledgement");
endmodule
`default_nettype wire

// File: rtl/pdvc_pkg.sv
// shared constants and types for the source-side voltage and current decrease sequencer
package pdvc_pkg;
   // ******************************
   // timing
   // ******************************
   localparam int unsigned CLK_PERIOD_NS = 8;
   // tSrcTransition, least wait before the supply is told to change
   localparam int unsigned T_SRC_TRANS_NS = 25000;
   // tSrcReady, longest time the supply may take to be ready
   localparam int unsigned T_SRC_READY_NS = 285000;
   // longest wait for an acknowledgement of a sent message
   localparam int unsigned CRC_WAIT_NS = 1000;
   localparam logic [23:0] T_SRC_TRANS_CYC =
      24'((T_SRC_TRANS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [23:0] T_SRC_READY_CYC = 24'(T_SRC_READY_NS / CLK_PERIOD_NS);
   localparam logic [23:0] CRC_WAIT_CYC = 24'(CRC_WAIT_NS / CLK_PERIOD_NS);
   localparam logic [23:0] TIMER_RST = 24'h000000;

   // ******************************
   // types
   // ******************************
   typedef enum logic [1:0] {
      PDVC_MSG_NONE,
      PDVC_MSG_ACCEPT,
      PDVC_MSG_PS_RDY
   } pdvc_msg_t;

   typedef struct packed {
      logic busy;
      logic done;
      logic err_crc;
      logic err_ready;
   } pdvc_stat_t;

   localparam pdvc_stat_t STAT_RST = '{busy: 1'b0, done: 1'b0, err_crc: 1'b0, err_ready: 1'b0};
endpackage

// File: verification/pdvc_sink_model.sv
// sink side model: message acknowledgement and transition timer
`timescale 1ns/100ps
`default_nettype none
module pdvc_sink_model #(
   parameter int ACK_DLY = 2,
   parameter int TMR_CYC = 200
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // source transmit side
   input wire logic tx_valid_i,
   input wire pdvc_pkg::pdvc_msg_t tx_msg_i,
   input wire logic ack_en_i,
   output logic tx_ready_o,
   output logic goodcrc_o,
   // sink policy status
   output logic lvl_ok_o,
   output logic tmr_err_o
);
   // ******************************
   // handshake capture and answers
   // ******************************
   logic hs_q;
   pdvc_pkg::pdvc_msg_t got_q;
   int wait_q;
   int tmr_q;
   logic tmr_on_q;
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         hs_q <= 1'b0;
         got_q <= pdvc_pkg::PDVC_MSG_NONE;
      end
      else
      begin
         hs_q <= tx_valid_i && tx_ready_o;
         got_q <= tx_msg_i;
      end
   end
   // the protocol layer takes every offered message at once
   assign tx_ready_o = tx_valid_i;
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         goodcrc_o <= 1'b0;
         wait_q <= 0;
         tmr_q <= 0;
         tmr_on_q <= 1'b0;
         lvl_ok_o <= 1'b0;
         tmr_err_o <= 1'b0;
      end
      else
      begin
         wait_q <= hs_q ? ACK_DLY : ((wait_q > 0) ? wait_q - 1 : 0);
         goodcrc_o <= (wait_q == 1) && ack_en_i;
         // accept clears lvl_ok_o and restarts the transition timer one cycle after its handshake
         if (hs_q && got_q == pdvc_pkg::PDVC_MSG_ACCEPT)
         begin
            tmr_on_q <= 1'b1;
            tmr_q <= 0;
            lvl_ok_o <= 1'b0;
         end
         else if (tmr_on_q)
            tmr_q <= tmr_q + 1;
         if (hs_q && got_q == pdvc_pkg::PDVC_MSG_PS_RDY)
         begin
            tmr_on_q <= 1'b0;
            lvl_ok_o <= 1'b1;
         end
         if (tmr_on_q && tmr_q == TMR_CYC)
            tmr_err_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: verification/test_pdvc_src_seq.sv
// testbench for the source decrease sequencer
`timescale 1ns/100ps
`default_nettype none
module test_pdvc_src_seq;
   // ******************************
   // bench
   // ******************************
   localparam logic [23:0] TC = 24'h000008;
   localparam logic [23:0] RC = 24'h000014;
   localparam logic [23:0] CC = 24'h00000A;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic req_rx_i = 1'b0;
   logic supply_ready_i = 1'b0;
   logic ack_en = 1'b1;
   logic goodcrc_rx_i, tx_ready_i, tx_valid_o, supply_cmd_o, lvl_ok, tmr_err;
   pdvc_pkg::pdvc_msg_t tx_msg_o;
   pdvc_pkg::pdvc_stat_t stat_o;
   int n_mismatch = 0;
   int num_checks = 0;
   always #4 core_clk_i = ~core_clk_i;
   pdvc_src_seq #(.TRANS_CYC(TC), .READY_CYC(RC), .CRC_CYC(CC)) i_dut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .req_rx_i(req_rx_i),
      .goodcrc_rx_i(goodcrc_rx_i), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
      .tx_msg_o(tx_msg_o), .supply_cmd_o(supply_cmd_o), .supply_ready_i(supply_ready_i),
      .stat_o(stat_o));
   pdvc_sink_model i_sink (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .tx_valid_i(tx_valid_o), .tx_msg_i(tx_msg_o),
      .ack_en_i(ack_en), .tx_ready_o(tx_ready_i), .goodcrc_o(goodcrc_rx_i),
      .lvl_ok_o(lvl_ok), .tmr_err_o(tmr_err));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic pulse_req();
      @(negedge core_clk_i) req_rx_i = 1'b1;
      @(negedge core_clk_i) req_rx_i = 1'b0;
      check("accept", {tx_valid_o, stat_o.busy, 30'(tx_msg_o)},
         {2'b11, 30'(pdvc_pkg::PDVC_MSG_ACCEPT)});
   endtask
   task automatic to_cmd(output int k);
      k = 0;
      pulse_req();
      while (goodcrc_rx_i !== 1'b1 && k < 50)
      begin
         @(negedge core_clk_i);
         k++;
      end
      k = 0;
      while (supply_cmd_o !== 1'b1 && k < 100)
      begin
         @(negedge core_clk_i);
         k++;
      end
      check("cmd delay", 32'(k), 32'(TC) + 32'h1);
   endtask
   task automatic test_normal();
      int k;
      to_cmd(k);
      repeat (3) @(negedge core_clk_i);
      check("early ps_rdy", 32'(tx_valid_o), 32'h0);
      supply_ready_i = 1'b1;
      @(negedge core_clk_i) supply_ready_i = 1'b0;
      check("ps_rdy", {tx_valid_o, 31'(tx_msg_o)}, {1'b1, 31'(pdvc_pkg::PDVC_MSG_PS_RDY)});
      k = 0;
      while (stat_o.done !== 1'b1 && k < 50)
      begin
         @(negedge core_clk_i);
         k++;
      end
      check("done", {30'h0, stat_o.done, stat_o.busy}, 32'h2);
      check("sink level", {30'h0, lvl_ok, tmr_err}, 32'h2);
      $display("test normal done");
   endtask
   task automatic test_no_ready();
      int k;
      to_cmd(k);
      k = 0;
      while (stat_o.err_ready !== 1'b1 && k < 100)
      begin
         @(negedge core_clk_i);
         k++;
         check("ps_rdy held", 32'(tx_valid_o), 32'h0);
      end
      check("ready timeout", {31'h0, stat_o.err_ready}, 32'h1);
      check("ready wait", 32'(k), 32'(RC) + 32'h1);
      check("sink level held", {30'h0, lvl_ok, tmr_err}, 32'h0);
      $display("test no ready done");
   endtask
   task automatic test_no_ack();
      int k;
      ack_en = 1'b0;
      pulse_req();
      k = 0;
      while (stat_o.err_crc !== 1'b1 && k < 100)
      begin
         @(negedge core_clk_i);
         k++;
         check("cmd held", 32'(supply_cmd_o), 32'h0);
      end
      check("crc timeout", {31'h0, stat_o.err_crc}, 32'h1);
      check("crc wait", 32'(k), 32'(CC) + 32'h1);
      ack_en = 1'b1;
      $display("test no ack done");
   endtask
   initial
   begin
      repeat (5) @(negedge core_clk_i);
      rst_i = 1'b0;
      test_normal();
      test_no_ready();
      test_no_ack();
      close_out();
   end
   initial
   begin
      #20000;
      n_mismatch++;
      close_out();
   end
endmodule
`default_nettype wire
